// ---- touch_grp_ctrl.sv ----
// group timing, recalibration control and interrupt gating of the touch sensor
// assumes register strobes from an outside serial engine and synchronous sensor levels
`default_nettype none
`include "touch_grp_consts.svh"
module touch_grp_ctrl #(
    parameter int TICK_CYCLES   = `TICK_CYCLES,
    parameter int ANALOG_CYCLES = `ANALOG_CYCLES,
    parameter int RECAL_MS      = `RECAL_MS
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output var  logic [7:0]  reg_rdata,
    input  wire logic [13:0] sense_input,
    input  wire logic [13:0] sample_en,
    input  wire logic [13:0] auto_recal_req,
    input  wire logic        hold_repeat_en,
    input  wire logic        group_max_press_recal_en,
    input  wire logic        slide_active,
    input  wire logic [7:0]  gpio_change,
    output var  logic [13:0] touch_valid,
    output var  logic [13:0] recal_busy,
    output var  logic [13:0] analog_update,
    output var  logic        tap_evt,
    output var  logic        hold_evt,
    output var  logic        hold_repeat_evt,
    output var  logic        slide_repeat_evt,
    output var  logic        irq_pulse
);
    // register file
    logic [7:0]  group_timing_cfg_a;
    logic [7:0]  group_timing_cfg_b;
    logic [7:0]  auto_recal_enable;
    logic [7:0]  recal_trigger_main;
    logic [7:0]  irq_enable_touch;
    logic [7:0]  irq_enable_gpio;
    logic [7:0]  recal_trigger_group;
    logic [7:0]  next_cfg_a;
    logic [7:0]  next_cfg_b;
    logic [7:0]  next_auto_en;
    logic [7:0]  next_trig_main;
    logic [7:0]  next_irq_touch;
    logic [7:0]  next_irq_gpio;
    logic [7:0]  next_trig_group;
    logic [7:0]  next_rdata;
    logic [6:0]  group_ok;
    logic [6:0]  next_group_ok;

    // time base and group timing state
    logic [15:0] tick_cnt;
    logic [15:0] next_tick_cnt;
    logic        tick;
    touch_grp_pkg::ms_t press_ms;
    touch_grp_pkg::ms_t next_press_ms;
    touch_grp_pkg::ms_t rpt_ms;
    touch_grp_pkg::ms_t next_rpt_ms;
    touch_grp_pkg::ms_t slide_ms;
    touch_grp_pkg::ms_t next_slide_ms;
    logic        pressed;
    logic        next_pressed;
    logic        held;
    logic        next_held;
    logic        max_fired;
    logic        next_max_fired;
    logic        tap_c;
    logic        hold_c;
    logic        hold_rpt_c;
    logic        slide_rpt_c;
    logic        max_recal_c;
    logic        irq_c;
    logic [13:0] valid_c;
    logic        group_touch;

    logic [13:0] eng_busy;
    logic [13:0] eng_done;
    logic [13:0] eng_analog;
    logic [13:0] start_c;

    // 35 ms steps, code 0 is 35 ms
    function automatic touch_grp_pkg::ms_t step_ms(input logic [3:0] code);
        step_ms = 14'(({10'h000, code} + 14'h0001) * 14'(`STEP_MS));
    endfunction

    // maximum press duration decode
    function automatic touch_grp_pkg::ms_t max_dur_ms(input logic [3:0] code);
        case (code)
            4'h0:    max_dur_ms = 14'd560;
            4'h1:    max_dur_ms = 14'd840;
            4'h2:    max_dur_ms = 14'd1120;
            4'h3:    max_dur_ms = 14'd1400;
            4'h4:    max_dur_ms = 14'd1680;
            4'h5:    max_dur_ms = 14'd2240;
            4'h6:    max_dur_ms = 14'd2800;
            4'h7:    max_dur_ms = 14'd3360;
            4'h8:    max_dur_ms = 14'd3920;
            4'h9:    max_dur_ms = 14'd4480;
            4'ha:    max_dur_ms = 14'd5600;
            4'hb:    max_dur_ms = 14'd6720;
            4'hc:    max_dur_ms = 14'd7840;
            4'hd:    max_dur_ms = 14'd8906;
            4'he:    max_dur_ms = 14'd10080;
            default: max_dur_ms = 14'd11200;
        endcase
    endfunction

    // recalibration engines, one per channel
    recal_if rif [14] ();
    genvar g;
    generate
        for (g = 0; g < 14; g++) begin : g_chan
            assign rif[g].tick  = tick;
            assign rif[g].start = start_c[g];
            assign rif[g].touch = sense_input[g];
            assign eng_busy[g]   = rif[g].busy;
            assign eng_done[g]   = rif[g].done;
            assign eng_analog[g] = rif[g].analog_upd;
            recal_engine #(
                .ANALOG_CYCLES (ANALOG_CYCLES),
                .RECAL_MS      (RECAL_MS)
            ) u_eng (
                .sys_clk (sys_clk),
                .resetn  (resetn),
                .ch      (rif[g].engine)
            );
        end
    endgenerate

    // recalibration start requests
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            start_c[i] = recal_trigger_main[i] // R16
                | (auto_recal_req[i] & auto_recal_enable[i] & sample_en[i]); // R8 R9
        end
        for (int i = 7; i < 14; i++) begin
            start_c[i] = recal_trigger_group[i-7] // R17
                | (recal_trigger_main[`GROUP_BIT] & ~group_ok[i-7]) // R15
                | (auto_recal_req[i] & auto_recal_enable[`GROUP_BIT] & sample_en[i]) // R10 R9
                | (max_recal_c & sample_en[i]); // R21
        end
    end

    // register writes, trigger self-clear, read data
    always_comb begin
        next_cfg_a      = group_timing_cfg_a;
        next_cfg_b      = group_timing_cfg_b;
        next_auto_en    = auto_recal_enable;
        next_irq_touch  = irq_enable_touch;
        next_irq_gpio   = irq_enable_gpio;
        next_group_ok   = recal_trigger_main[`GROUP_BIT] ? (group_ok | eng_done[13:7]) : 7'h00;
        next_trig_main  = recal_trigger_main & ~{1'b0, eng_done[6:0]}; // R11 R16
        next_trig_group = recal_trigger_group & ~{1'b0, eng_done[13:7]}; // R11 R17
        if (&next_group_ok) begin
            next_trig_main[`GROUP_BIT] = 1'b0; // R15
            next_group_ok = 7'h00;
        end
        if (reg_wr) begin
            case (reg_addr)
                `ADDR_CFG_A:      next_cfg_a     = reg_wdata;
                `ADDR_CFG_B:      next_cfg_b     = reg_wdata;
                `ADDR_AUTO_EN:    next_auto_en   = reg_wdata;
                `ADDR_TRIG_MAIN:  next_trig_main = reg_wdata;
                `ADDR_IRQ_TOUCH:  next_irq_touch = reg_wdata;
                `ADDR_IRQ_GPIO:   next_irq_gpio  = reg_wdata;
                `ADDR_TRIG_GROUP: next_trig_group = {1'b0, reg_wdata[6:0]}; // R17
                default:          next_cfg_a     = group_timing_cfg_a;
            endcase
        end
        case (reg_addr)
            `ADDR_CFG_A:      next_rdata = group_timing_cfg_a;
            `ADDR_CFG_B:      next_rdata = group_timing_cfg_b;
            `ADDR_AUTO_EN:    next_rdata = auto_recal_enable;
            `ADDR_TRIG_MAIN:  next_rdata = recal_trigger_main;
            `ADDR_IRQ_TOUCH:  next_rdata = irq_enable_touch;
            `ADDR_IRQ_GPIO:   next_rdata = irq_enable_gpio;
            `ADDR_TRIG_GROUP: next_rdata = recal_trigger_group;
            default:          next_rdata = 8'h00;
        endcase
    end

    // ms time base
    always_comb begin
        tick          = (tick_cnt == 16'(TICK_CYCLES - 1)); // R23
        next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
    end

    // group tap, hold, repeat, slide and max press timing
    always_comb begin
        valid_c        = sense_input & sample_en & ~eng_busy; // R13
        group_touch    = |valid_c[13:7];
        next_press_ms  = press_ms;
        next_rpt_ms    = rpt_ms;
        next_slide_ms  = slide_ms;
        next_pressed   = pressed;
        next_held      = held;
        next_max_fired = max_fired;
        tap_c          = 1'b0;
        hold_c         = 1'b0;
        hold_rpt_c     = 1'b0;
        slide_rpt_c    = 1'b0;
        max_recal_c    = 1'b0;
        if (group_touch) begin
            next_pressed = 1'b1;
            if (tick && press_ms != 14'h3fff) begin
                next_press_ms = press_ms + 14'h0001;
            end
            if (!held && press_ms > step_ms(group_timing_cfg_a[`FLD_LO])) begin // R5
                next_held   = 1'b1;
                hold_c      = 1'b1; // R2
                next_rpt_ms = 14'h0000;
            end
            if (held && hold_repeat_en && tick) begin
                if (rpt_ms + 14'h0001 >= step_ms(group_timing_cfg_a[`FLD_HI])) begin // R1 R19
                    hold_rpt_c  = 1'b1;
                    next_rpt_ms = 14'h0000;
                end else begin
                    next_rpt_ms = rpt_ms + 14'h0001;
                end
            end
            if (group_max_press_recal_en && !max_fired
                && press_ms > max_dur_ms(group_timing_cfg_b[`FLD_HI])) begin // R6 R20
                max_recal_c    = 1'b1; // R21
                next_max_fired = 1'b1;
            end
        end else begin
            tap_c          = pressed & ~held; // R3
            next_pressed   = 1'b0;
            next_held      = 1'b0;
            next_max_fired = 1'b0;
            next_press_ms  = 14'h0000;
            next_rpt_ms    = 14'h0000;
        end
        // slides counted apart from the hold timing
        if (slide_active) begin // R4
            if (tick) begin
                if (slide_ms + 14'h0001 >= step_ms(group_timing_cfg_b[`FLD_LO])) begin // R7 R19
                    slide_rpt_c   = 1'b1;
                    next_slide_ms = 14'h0000;
                end else begin
                    next_slide_ms = slide_ms + 14'h0001;
                end
            end
        end else begin
            next_slide_ms = 14'h0000;
        end
        irq_c = (irq_enable_touch[`GROUP_BIT]
                 & (tap_c | hold_c | hold_rpt_c | slide_rpt_c)) // R22
              | (|(irq_enable_touch[6:0] & valid_c[6:0] & ~touch_valid[6:0])) // R18
              | (|(irq_enable_gpio & gpio_change)); // R18
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            group_timing_cfg_a  <= `RST_CFG_A;
            group_timing_cfg_b  <= `RST_CFG_B;
            auto_recal_enable   <= `RST_AUTO_EN;
            recal_trigger_main  <= `RST_TRIG;
            irq_enable_touch    <= `RST_IRQ_TOUCH;
            irq_enable_gpio     <= `RST_IRQ_GPIO;
            recal_trigger_group <= `RST_TRIG;
            group_ok            <= 7'h00;
            reg_rdata           <= 8'h00;
            tick_cnt            <= 16'h0000;
            press_ms            <= 14'h0000;
            rpt_ms              <= 14'h0000;
            slide_ms            <= 14'h0000;
            pressed             <= 1'b0;
            held                <= 1'b0;
            max_fired           <= 1'b0;
            touch_valid         <= 14'h0000;
            recal_busy          <= 14'h0000;
            analog_update       <= 14'h0000;
            tap_evt             <= 1'b0;
            hold_evt            <= 1'b0;
            hold_repeat_evt     <= 1'b0;
            slide_repeat_evt    <= 1'b0;
            irq_pulse           <= 1'b0;
        end else begin
            group_timing_cfg_a  <= next_cfg_a;
            group_timing_cfg_b  <= next_cfg_b;
            auto_recal_enable   <= next_auto_en;
            recal_trigger_main  <= next_trig_main;
            irq_enable_touch    <= next_irq_touch;
            irq_enable_gpio     <= next_irq_gpio;
            recal_trigger_group <= next_trig_group;
            group_ok            <= next_group_ok;
            reg_rdata           <= next_rdata;
            tick_cnt            <= next_tick_cnt;
            press_ms            <= next_press_ms;
            rpt_ms              <= next_rpt_ms;
            slide_ms            <= next_slide_ms;
            pressed             <= next_pressed;
            held                <= next_held;
            max_fired           <= next_max_fired;
            touch_valid         <= valid_c;
            recal_busy          <= eng_busy;
            analog_update       <= eng_analog;
            tap_evt             <= tap_c;
            hold_evt            <= hold_c;
            hold_repeat_evt     <= hold_rpt_c;
            slide_repeat_evt    <= slide_rpt_c;
            irq_pulse           <= irq_c;
        end
    end
endmodule // touch_grp_ctrl
`default_nettype wire

// ---- touch_grp_consts.svh ----
// offsets, field positions, reset values and timing counts of the group timing block
// assumes a 25 MHz system clock and an outside serial engine that issues register strobes
// Operation
// (R1) group_timing_cfg_a bits 7-4 set hold repeat interval, reset 0100b.
// (R2) grouped touch longer than minimum-hold field reports press-and-hold; reset 0111b.
// (R3) grouped touch not longer than minimum-hold setting reports a tap.
// (R4) minimum-hold setting never affects slides; slides are independent events.
// (R5) minimum-hold field decodes as 35 ms times code plus one.
// (R6) group_timing_cfg_b bits 7-4 set longest press before recalibration; reset 1101b.
// (R7) group_timing_cfg_b bits 3-0 set slide repeat base interval; reset 0100b.
// (R8) each auto_recal_enable bit selects automatic recalibration; bit 7 covers group; reset ones.
// (R9) auto recalibration enable is ignored for channels not sampled.
// (R10) group auto bit zero: grouped channels recalibrate only by host trigger; the code also starts them on a max press when group_max_press_recal_en is set.
// (R11) set trigger bit starts recalibration; device clears it on completion.
// (R12) recalibration updates analog settings first, then digital base capture.
// (R13) recalibrating sensors report no touches, up to 600 ms, base invalid.
// (R14) touch during recalibration invalidates it; trigger bit stays set.
// (R15) main trigger bit 7 recalibrates all grouped channels; clears after all succeed.
// (R16) main trigger bits 6-0 recalibrate channels 7-1, each self-clearing.
// (R17) group trigger bits 6-0 recalibrate channels 14-8; bit 7 unused.
// (R18) two interrupt enables gate the pin: touch reset ffh, gpio reset 00h.
// (R19) repeat interval fields decode as 35 ms times code plus one.
// (R20) maximum press field decodes nonlinearly, 560 ms to 11200 ms.
// (R21) press longer than maximum duration, when enabled, restarts recalibration.
// (R22) touch enable bit 7 gates grouped slide, tap and hold interrupts.
// (R23) millisecond intervals are counted from a 1 ms tick of the clock.
`ifndef TOUCH_GRP_CONSTS_SVH
`define TOUCH_GRP_CONSTS_SVH

`define ADDR_CFG_A        8'h23
`define ADDR_CFG_B        8'h24
`define ADDR_AUTO_EN      8'h25
`define ADDR_TRIG_MAIN    8'h26
`define ADDR_IRQ_TOUCH    8'h27
`define ADDR_IRQ_GPIO     8'h28
`define ADDR_TRIG_GROUP   8'h46

`define RST_CFG_A         8'h47
`define RST_CFG_B         8'hd4
`define RST_AUTO_EN       8'hff
`define RST_TRIG          8'h00
`define RST_IRQ_TOUCH     8'hff
`define RST_IRQ_GPIO      8'h00

`define FLD_HI            7:4
`define FLD_LO            3:0
`define GROUP_BIT         7

`define CLK_PERIOD_NS     40
`define TICK_NS           1000000
`define TICK_CYCLES       (`TICK_NS / `CLK_PERIOD_NS)
`define STEP_MS           35
`define RECAL_MS          600
`define ANALOG_CYCLES     8

`endif

// ---- touch_grp_pkg.sv ----
// types shared by the group timing block
// assumes nothing of its surroundings
`default_nettype none
package touch_grp_pkg;
    typedef enum logic [1:0] {
        RC_IDLE,
        RC_ANALOG,
        RC_DIGITAL
    } recal_state_t;
    typedef logic [13:0] ms_t;
endpackage
`default_nettype wire

// ---- recal_if.sv ----
// handshake between the controller and one channel recalibration engine
// assumes a single clock domain
`default_nettype none
interface recal_if;
    logic tick;
    logic start;
    logic touch;
    logic busy;
    logic analog_upd;
    logic done;
    logic fail;
    modport ctrl   (output tick, start, touch, input busy, analog_upd, done, fail);
    modport engine (input tick, start, touch, output busy, analog_upd, done, fail);
endinterface
`default_nettype wire

// ---- recal_engine.sv ----
// one channel recalibration sequence: analog update, then digital base capture
// assumes tick pulses once per ms and touch is the raw channel level
`default_nettype none
`include "touch_grp_consts.svh"
module recal_engine #(
    parameter int ANALOG_CYCLES = `ANALOG_CYCLES,
    parameter int RECAL_MS      = `RECAL_MS
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    recal_if.engine   ch
);
    touch_grp_pkg::recal_state_t state;
    touch_grp_pkg::recal_state_t next_state;
    logic [9:0]                  cnt;
    logic [9:0]                  next_cnt;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        ch.done    = 1'b0;
        ch.fail    = 1'b0;
        case (state)
            touch_grp_pkg::RC_IDLE: begin
                if (ch.start) begin
                    next_state = touch_grp_pkg::RC_ANALOG;
                    next_cnt   = 10'h000;
                end
            end
            touch_grp_pkg::RC_ANALOG: begin
                if (ch.touch) begin
                    ch.fail    = 1'b1; // R14
                    next_state = touch_grp_pkg::RC_IDLE;
                end else if (cnt == 10'(ANALOG_CYCLES - 1)) begin
                    next_state = touch_grp_pkg::RC_DIGITAL; // R12
                    next_cnt   = 10'h000;
                end else begin
                    next_cnt = cnt + 10'h001;
                end
            end
            touch_grp_pkg::RC_DIGITAL: begin
                if (ch.touch) begin
                    ch.fail    = 1'b1; // R14
                    next_state = touch_grp_pkg::RC_IDLE;
                end else if (ch.tick) begin
                    if (cnt == 10'(RECAL_MS - 1)) begin
                        ch.done    = 1'b1; // R13
                        next_state = touch_grp_pkg::RC_IDLE;
                    end else begin
                        next_cnt = cnt + 10'h001;
                    end
                end
            end
            default: next_state = touch_grp_pkg::RC_IDLE;
        endcase
    end

    assign ch.busy       = (state != touch_grp_pkg::RC_IDLE);
    assign ch.analog_upd = (state == touch_grp_pkg::RC_ANALOG); // R12

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= touch_grp_pkg::RC_IDLE;
            cnt   <= 10'h000;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end
endmodule // recal_engine
`default_nettype wire

// ---- touch_grp_ctrl_assertions.sv ----
// port checker of the group timing block
// assumes binding onto touch_grp_ctrl, one clock domain
`default_nettype none
module touch_grp_ctrl_assertions (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_rdata,
    input wire logic [13:0] sense_input,
    input wire logic [13:0] sample_en,
    input wire logic        hold_repeat_en,
    input wire logic        slide_active,
    input wire logic [13:0] touch_valid,
    input wire logic [13:0] recal_busy,
    input wire logic [13:0] analog_update,
    input wire logic        tap_evt,
    input wire logic        hold_evt,
    input wire logic        hold_repeat_evt,
    input wire logic        slide_repeat_evt
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence analog_start;
        $rose(analog_update[0]);
    endsequence
    sequence analog_run;
        analog_update[0] [*8] ##1 !analog_update[0];
    endsequence
    analog_phase_a: assert property (analog_start |-> analog_run)
        else $error("analog phase length wrong");
    analog_busy_a: assert property ((analog_update & ~recal_busy) == 14'h0000)
        else $error("analog phase outside busy");
    touch_gate_a: assert property ((touch_valid & ~$past(sense_input & sample_en)) == 14'h0000)
        else $error("touch reported without sampled press");
    unmapped_read_a: assert property (!($past(reg_addr) inside {8'h23, 8'h24, 8'h25,
        8'h26, 8'h27, 8'h28, 8'h46}) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    tap_pulse_a: assert property (tap_evt |=> !tap_evt)
        else $error("tap event longer than one cycle");
    hold_pulse_a: assert property (hold_evt |=> !hold_evt)
        else $error("hold event longer than one cycle");
    tap_hold_excl_a: assert property (!(tap_evt && hold_evt))
        else $error("tap and hold together");
    hold_rpt_gate_a: assert property (hold_repeat_evt |->
        ($past(hold_repeat_en) || $past(hold_repeat_en, 2)))
        else $error("hold repeat while disabled");
    slide_rpt_gate_a: assert property (slide_repeat_evt |->
        ($past(slide_active) || $past(slide_active, 2)))
        else $error("slide repeat without slide");
endmodule // touch_grp_ctrl_assertions
bind touch_grp_ctrl touch_grp_ctrl_assertions chk (.sys_clk, .resetn, .reg_addr, .reg_rdata,
    .sense_input, .sample_en, .hold_repeat_en, .slide_active, .touch_valid, .recal_busy,
    .analog_update, .tap_evt, .hold_evt, .hold_repeat_evt, .slide_repeat_evt);
`default_nettype wire

// ---- touch_host_model.sv ----
// host side of the register strobe bus
// assumes writes taken on the edge with reg_wr high, read data one cycle late
`default_nettype none
module touch_host_model (
    input  wire logic       sys_clk,
    output var  logic       reg_wr,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #2;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #2;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #2;
        reg_addr = a;
        @(posedge sys_clk);
        @(posedge sys_clk);
        #1;
        d = reg_rdata;
    endtask
endmodule // touch_host_model
`default_nettype wire

// ---- touch_grp_ctrl_bench.sv ----
// self-checking bench of the group timing block with a register model
// assumes short tick and recalibration counts set by parameter
`default_nettype none
`include "touch_grp_consts.svh"
module touch_grp_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, resetn = 1'b0, reg_wr, hold_repeat_en, slide_active;
    logic group_max_press_recal_en, tap_evt, hold_evt, hold_repeat_evt, slide_repeat_evt;
    logic irq_pulse;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, gpio_change, v;
    logic [13:0] sense_input, sample_en, auto_recal_req, touch_valid, recal_busy, analog_update;
    logic [7:0] mdl [0:255];
    logic [7:0] regs [7] = '{`ADDR_CFG_A, `ADDR_CFG_B, `ADDR_AUTO_EN, `ADDR_TRIG_MAIN,
        `ADDR_IRQ_TOUCH, `ADDR_IRQ_GPIO, `ADDR_TRIG_GROUP};
    logic [7:0] trg [4][2] = '{'{`ADDR_TRIG_MAIN, 8'h01}, '{`ADDR_TRIG_MAIN, 8'h80},
        '{`ADDR_TRIG_GROUP, 8'h01}, '{`ADDR_TRIG_GROUP, 8'h40}};
    int miscompares = 0, tests_run = 0, seed = 40506;
    int n_tap = 0, n_hold = 0, n_hrep = 0, n_srep = 0, n_irq = 0, seen_an = 0;
    always #20 sys_clk = ~sys_clk;
    touch_grp_ctrl #(.TICK_CYCLES(10), .RECAL_MS(4)) dut (.sys_clk, .resetn, .reg_wr,
        .reg_addr, .reg_wdata, .reg_rdata, .sense_input, .sample_en, .auto_recal_req,
        .hold_repeat_en, .group_max_press_recal_en, .slide_active, .gpio_change,
        .touch_valid, .recal_busy, .analog_update, .tap_evt, .hold_evt, .hold_repeat_evt,
        .slide_repeat_evt, .irq_pulse);
    touch_host_model host (.sys_clk, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);
    always @(posedge sys_clk) begin
        n_tap += (tap_evt === 1'b1);
        n_hold += (hold_evt === 1'b1);
        n_hrep += (hold_repeat_evt === 1'b1);
        n_srep += (slide_repeat_evt === 1'b1);
        n_irq += (irq_pulse === 1'b1);
        if (analog_update[0] === 1'b1 && recal_busy[0] === 1'b1) seen_an = 1;
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic checkn(string what, int exp, int got);
        tests_run++;
        if (got != exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic wrm(logic [7:0] a, logic [7:0] d);
        host.wr(a, d);
        mdl[a] = (a == `ADDR_TRIG_GROUP) ? (d & 8'h7f) : d;
    endtask
    task automatic rdc(logic [7:0] a);
        host.rd(a, v);
        check8($sformatf("register %h", a), mdl[a], v);
    endtask
    task automatic wait_clear(logic [7:0] a, logic [7:0] m);
        for (int i = 0; i < 100; i++) begin
            host.rd(a, v);
            if ((v & m) === 8'h00) return;
        end
        miscompares++;
        $display("[FAIL] trigger clear expected 00 seen %h", v & m);
        finish_test();
    endtask
    task automatic press(int ch, int cyc, logic sl);
        @(posedge sys_clk);
        #2;
        sense_input[ch] = 1'b1;
        slide_active = sl;
        repeat (cyc) @(posedge sys_clk);
        #2;
        sense_input[ch] = 1'b0;
        slide_active = 1'b0;
        repeat (20) @(posedge sys_clk);
    endtask
    initial begin
        {hold_repeat_en, slide_active, group_max_press_recal_en} = 3'b000;
        {sense_input, auto_recal_req, gpio_change} = '0;
        sample_en = 14'h3fff;
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[`ADDR_CFG_A] = `RST_CFG_A;
        mdl[`ADDR_CFG_B] = `RST_CFG_B;
        mdl[`ADDR_AUTO_EN] = `RST_AUTO_EN;
        mdl[`ADDR_IRQ_TOUCH] = `RST_IRQ_TOUCH;
        repeat (12) @(posedge sys_clk);
        #2 resetn = 1'b1;
        foreach (regs[i]) rdc(regs[i]);
        rdc(8'h30);
        $display("test reset values done");
        foreach (regs[i]) if (i != 3) begin
            wrm(regs[i], 8'($random(seed)));
            rdc(regs[i]);
        end
        $display("test write readback done");
        foreach (trg[i]) begin
            wrm(trg[i][0], trg[i][1]);
            wait_clear(trg[i][0], trg[i][1]);
            mdl[trg[i][0]] = 8'h00;
            rdc(trg[i][0]);
        end
        checkn("analog phase seen", 1, seen_an);
        wrm(`ADDR_TRIG_MAIN, 8'h02);
        repeat (20) @(posedge sys_clk);
        press(1, 1, 1'b0);
        repeat (10) @(posedge sys_clk);
        host.rd(`ADDR_TRIG_MAIN, v);
        check8("aborted trigger", 8'h02, v);
        wait_clear(`ADDR_TRIG_MAIN, 8'h02);
        $display("test recalibration done");
        wrm(`ADDR_CFG_A, 8'h00);
        wrm(`ADDR_CFG_B, 8'h00);
        wrm(`ADDR_IRQ_TOUCH, 8'hff);
        {n_tap, n_hold, n_irq} = '0;
        press(7, 100, 1'b0);
        checkn("tap count", 1, n_tap);
        checkn("hold after tap", 0, n_hold);
        checkn("group irq", 1, n_irq);
        hold_repeat_en = 1'b1;
        {n_tap, n_hold, n_hrep, n_srep} = '0;
        press(7, 800, 1'b1);
        checkn("hold count", 1, n_hold);
        checkn("tap after hold", 0, n_tap);
        checkn("hold repeats", 1, n_hrep);
        checkn("slide repeats", 2, n_srep);
        $display("test group events done");
        for (int e = 0; e < 2; e++) begin
            wrm(`ADDR_IRQ_GPIO, e[7:0]);
            n_irq = 0;
            gpio_change = 8'h01;
            @(posedge sys_clk);
            #2 gpio_change = 8'h00;
            repeat (5) @(posedge sys_clk);
            checkn("gpio irq", e, n_irq);
        end
        $display("test gpio gating done");
        wrm(`ADDR_AUTO_EN, 8'h7f);
        {sample_en[0], auto_recal_req} = {1'b0, 14'h0081};
        repeat (5) @(posedge sys_clk);
        check8("auto recal off", 8'h00, recal_busy[7:0] & 8'h81);
        wrm(`ADDR_AUTO_EN, 8'hff);
        sample_en[0] = 1'b1;
        repeat (5) @(posedge sys_clk);
        check8("auto recal on", 8'h81, recal_busy[7:0] & 8'h81);
        $display("test auto recalibration done");
        finish_test();
    end
endmodule // touch_grp_ctrl_bench
`default_nettype wire
